/* File: include/pwg_defs.vh */
/*
  Constants for the parameter write guard and direction lock block:
  bus offsets, parameter slots, reset values, selector codes and
  status bit positions.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PWG_DEFS_VH
`define PWG_DEFS_VH

// Register byte offsets on the bus.
`define PWG_OFS_PWRITE   8'h00
`define PWG_OFS_PCLEAR   8'h04
`define PWG_OFS_STATUS   8'h08
`define PWG_OFS_PREAD    8'h40
`define PWG_AMASK_PREAD  8'hc0

// Field positions of the parameter write and parameter clear words.
`define PWG_PW_IDX_HI    19
`define PWG_PW_IDX_LO    16
`define PWG_PW_VAL_HI    15
`define PWG_PW_VAL_LO    0
`define PWG_PC_CLEAR     0
`define PWG_PC_ALLCLR    1

// Parameter slot numbers.
`define PWG_P_WGUARD     4'h0
`define PWG_P_DIRLOCK    4'h1
`define PWG_P_RSTSEL     4'h2
`define PWG_P_OPMODE     4'h3
`define PWG_P_ALWAYS_A   4'h4
`define PWG_P_PROT_B     4'h5
`define PWG_P_METHOD     4'h6
`define PWG_NPARAM       16

// Reset values.
`define PWG_DFLT_RSTSEL  16'h000e
`define PWG_DFLT_OTHER   16'h0000

// Selector codes.
`define PWG_GUARD_PANEL  16'h0000
`define PWG_GUARD_LOCKED 16'h0001
`define PWG_GUARD_OPEN   16'h0002
`define PWG_LOCK_NONE    16'h0000
`define PWG_LOCK_REV     16'h0001
`define PWG_LOCK_FWD     16'h0002
`define PWG_METH_SPEED   16'h0000
`define PWG_METH_TORQUE  16'h0001
`define PWG_METH_POS     16'h0002
`define PWG_OPM_EXTSW    16'h0000
`define PWG_OPM_PANEL    16'h0001
`define PWG_OPM_EXT      16'h0002
`define PWG_OPM_COMB1    16'h0003
`define PWG_OPM_COMB2    16'h0004
`define PWG_RSTSEL_ANY   16'h000e
`define PWG_RSTSEL_MODE  16'h0002

// Status bit positions.
`define PWG_ST_REJECT    0
`define PWG_ST_RUNNING   1
`define PWG_ST_PSTOP     2
`define PWG_ST_MODE_LO   3
`define PWG_ST_SHUTOFF   7

`endif

/* File: rtl/pwg_guard_lock.v */
/*
  Parameter write guard, rotation direction lock, operator panel stop
  and reset terminal handling of a motor drive, with an AHB-Lite slave.
  Assumes a single 40 MHz clock, inputs synchronous to it, and a drive
  core that reports running, speed and fault state.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pwg_defs.vh"

// Notes on behaviour
// - Guard 0: writes only while stopped in panel operation mode, or to the reset/stop selection.
// - Guard 1: writes refused except the always-writable set.
// - Guard 2: writes accepted while running, in any mode.
// - Guard 2: protected parameters still need the motor stopped.
// - Guard 1: parameter clear and all-clear are refused.
// - Guard 1: guard, reset/stop, mode select, parameter A stay writable.
// - Direction lock acts in every operation mode.
// - Lock 0 speed/torque: both starts valid, negative command reverses.
// - Lock 1 ignores reverse start; lock 2 ignores forward start.
// - Speed control with lock: negative command does not start rotation.
// - Torque with lock: negative gives nothing below start speed, else opposing torque.
// - Position lock 0: start inputs act as stroke limits.
// - Reset terminal during run shuts output off, clears thermal data.
// - Panel stop is also released by power-on or terminal reset.
// - Panel stop shows its indication and never raises the alarm.
// - Reset/stop selection is always writable and survives clears.
// - Default mode selection enters external mode at power on.
module pwg_guard_lock (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        srst_i,
  // AHB-Lite slave.
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire        hready_i,
  input  wire [31:0] hwdata_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Start, reset and panel inputs.
  input  wire        forward_start_input_i,
  input  wire        reverse_start_input_i,
  input  wire        reset_terminal_input_i,
  input  wire        panel_stop_key_i,
  input  wire        panel_set_key_i,
  input  wire        mode_toggle_i,
  input  wire        comm_mode_req_i,
  // Drive core state.
  input  wire        motor_running_i,
  input  wire        analog_negative_i,
  input  wire        above_start_speed_i,
  input  wire        fault_i,
  // Drive core commands.
  output reg         run_o,
  output reg         dir_forward_o,
  output reg         torque_oppose_o,
  output reg         allow_forward_o,
  output reg         allow_reverse_o,
  output reg         output_shutoff_o,
  output reg         thermal_clear_o,
  output reg         panel_stop_indication_o,
  output reg         alarm_o
);

  localparam [3:0] MD_EXT   = 4'h1;
  localparam [3:0] MD_PANEL = 4'h2;
  localparam [3:0] MD_COMB  = 4'h4;
  localparam [3:0] MD_COMM  = 4'h8;

  reg  [3:0]  mode_q;
  reg  [3:0]  mode_d;
  reg         wr_pend_q;
  reg  [7:0]  wr_addr_q;
  reg         reject_q;
  reg         pstop_q;
  wire [15:0] prm_w [0:`PWG_NPARAM-1];
  wire [15:0] guard_w;
  wire [15:0] lock_w;
  wire [15:0] rstsel_w;
  wire [15:0] opsel_w;
  wire [15:0] meth_w;
  wire        addr_ph;
  wire        pw_req;
  wire        pc_req;
  wire [3:0]  pw_idx;
  wire        clr_req;
  reg         pw_ok;
  wire        clr_ok;
  wire        always_set;
  wire        protected_p;
  wire        stopped;
  wire        rst_ok;
  wire        pstop_ok;
  wire        fwd_ok;
  wire        rev_ok;

  assign guard_w  = prm_w[`PWG_P_WGUARD];
  assign lock_w   = prm_w[`PWG_P_DIRLOCK];
  assign rstsel_w = prm_w[`PWG_P_RSTSEL];
  assign opsel_w  = prm_w[`PWG_P_OPMODE];
  assign meth_w   = prm_w[`PWG_P_METHOD];
  assign stopped  = ~motor_running_i;

  // The slave always answers at once with OKAY.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign addr_ph     = hsel_i & htrans_i[1] & hready_i;

  // Write requests are decoded in the data phase of the transfer.
  assign pw_req  = wr_pend_q & (wr_addr_q == `PWG_OFS_PWRITE);
  assign pc_req  = wr_pend_q & (wr_addr_q == `PWG_OFS_PCLEAR);
  assign pw_idx  = hwdata_i[`PWG_PW_IDX_HI:`PWG_PW_IDX_LO];
  assign clr_req = pc_req & (hwdata_i[`PWG_PC_CLEAR] |
                             hwdata_i[`PWG_PC_ALLCLR]);

  // Classify the target parameter.
  assign always_set  = (pw_idx == `PWG_P_WGUARD) |
                       (pw_idx == `PWG_P_RSTSEL) |
                       (pw_idx == `PWG_P_OPMODE) |
                       (pw_idx == `PWG_P_ALWAYS_A);
  assign protected_p = (pw_idx == `PWG_P_OPMODE) |
                       (pw_idx == `PWG_P_PROT_B);

  // Write guard decision for a parameter write.
  always @* begin
    case (guard_w)
      `PWG_GUARD_PANEL:
        pw_ok = (stopped & (mode_q == MD_PANEL)) |
                (pw_idx == `PWG_P_RSTSEL);
      `PWG_GUARD_LOCKED:
        pw_ok = always_set;
      `PWG_GUARD_OPEN:
        pw_ok = ~(motor_running_i & protected_p);
      default:
        pw_ok = 1'b0;
    endcase
  end

  // Clears are refused under guard 1 and while running.
  assign clr_ok = (guard_w != `PWG_GUARD_LOCKED) & stopped;

  // Parameter storage, one entry per slot; refused requests leave it alone.
  genvar g;
  generate
    for (g = 0; g < `PWG_NPARAM; g = g + 1) begin : g_prm
      localparam [15:0] DFLT = (g == `PWG_P_RSTSEL) ?
                               `PWG_DFLT_RSTSEL : `PWG_DFLT_OTHER;
      reg [15:0] val_q;
      always @(posedge clk_i) begin
        if (srst_i) begin
          val_q <= DFLT;
        end else if (pw_req & pw_ok & (pw_idx == g)) begin
          val_q <= hwdata_i[`PWG_PW_VAL_HI:`PWG_PW_VAL_LO];
        end else if (clr_req & clr_ok & (g != `PWG_P_RSTSEL)) begin
          val_q <= DFLT;
        end
      end
      assign prm_w[g] = val_q;
    end
  endgenerate

  // Bus address phase capture and read data.
  always @(posedge clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_o  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ph & hwrite_i;
      if (addr_ph) begin
        wr_addr_q <= haddr_i;
      end
      if (addr_ph & ~hwrite_i) begin
        if ((haddr_i & `PWG_AMASK_PREAD) == `PWG_OFS_PREAD) begin
          hrdata_o <= {16'h0000, prm_w[haddr_i[5:2]]};
        end else if (haddr_i == `PWG_OFS_STATUS) begin
          hrdata_o <= {24'h00_0000, output_shutoff_o, mode_q,
                       pstop_q, motor_running_i, reject_q};
        end else begin
          hrdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  // Result of the last write or clear request.
  always @(posedge clk_i) begin
    if (srst_i) begin
      reject_q <= 1'b0;
    end else if (pw_req) begin
      reject_q <= ~pw_ok;
    end else if (clr_req) begin
      reject_q <= ~clr_ok;
    end
  end

  // Operation mode; the default selection starts in external mode.
  always @* begin
    mode_d = mode_q;
    case (opsel_w)
      `PWG_OPM_PANEL: mode_d = MD_PANEL;
      `PWG_OPM_EXT:   mode_d = MD_EXT;
      `PWG_OPM_COMB1: mode_d = MD_COMB;
      `PWG_OPM_COMB2: mode_d = MD_COMB;
      default: begin
        if (stopped & comm_mode_req_i) begin
          mode_d = MD_COMM;
        end else if (stopped & mode_toggle_i) begin
          mode_d = (mode_q == MD_PANEL) ? MD_EXT : MD_PANEL;
        end else if (mode_q == MD_COMB) begin
          mode_d = MD_EXT;
        end
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= MD_EXT;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Reset terminal acceptance follows the reset/stop selection.
  assign rst_ok = reset_terminal_input_i &
                  (~rstsel_w[0] | fault_i);
  // Panel stop key validity follows the reset/stop selection.
  assign pstop_ok = (rstsel_w >= `PWG_RSTSEL_ANY) |
                    ((rstsel_w >= `PWG_RSTSEL_MODE) &
                     (rstsel_w < `PWG_RSTSEL_ANY) &
                     ((mode_q == MD_PANEL) | (mode_q == MD_COMB)));

  // Panel stop latch; a new stop wins over a release in the same cycle.
  always @(posedge clk_i) begin
    if (srst_i) begin
      pstop_q <= 1'b0;
    end else if (panel_stop_key_i & pstop_ok & motor_running_i) begin
      pstop_q <= 1'b1;
    end else if (rst_ok) begin
      pstop_q <= 1'b0;
    end else if (panel_set_key_i & stopped &
                 ~forward_start_input_i & ~reverse_start_input_i) begin
      pstop_q <= 1'b0;
    end
  end

  // Start inputs qualified by the lock, regardless of mode.
  assign fwd_ok = forward_start_input_i &
                  (lock_w != `PWG_LOCK_FWD);
  assign rev_ok = reverse_start_input_i &
                  (lock_w != `PWG_LOCK_REV);

  // Drive commands, gated by panel stop and terminal reset.
  always @(posedge clk_i) begin
    if (srst_i) begin
      run_o                   <= 1'b0;
      dir_forward_o           <= 1'b0;
      torque_oppose_o         <= 1'b0;
      allow_forward_o         <= 1'b0;
      allow_reverse_o         <= 1'b0;
      output_shutoff_o        <= 1'b0;
      thermal_clear_o         <= 1'b0;
      panel_stop_indication_o <= 1'b0;
      alarm_o                 <= 1'b0;
    end else begin
      output_shutoff_o        <= rst_ok;
      thermal_clear_o         <= rst_ok;
      panel_stop_indication_o <= pstop_q;
      alarm_o                 <= fault_i & ~pstop_q;
      torque_oppose_o         <= 1'b0;
      allow_forward_o         <= 1'b0;
      allow_reverse_o         <= 1'b0;
      dir_forward_o           <= fwd_ok;
      run_o                   <= 1'b0;
      if (~pstop_q & ~rst_ok) begin
        if (meth_w == `PWG_METH_POS) begin
          run_o           <= fwd_ok | rev_ok;
          allow_forward_o <= fwd_ok;
          allow_reverse_o <= rev_ok;
        end else if (lock_w == `PWG_LOCK_NONE) begin
          run_o         <= fwd_ok | rev_ok;
          dir_forward_o <= fwd_ok ^ analog_negative_i;
        end else if (~analog_negative_i) begin
          run_o <= fwd_ok | rev_ok;
        end else if (meth_w == `PWG_METH_TORQUE) begin
          run_o           <= (fwd_ok | rev_ok) &
                             above_start_speed_i;
          torque_oppose_o <= (fwd_ok | rev_ok) &
                             above_start_speed_i;
        end else begin
          run_o <= 1'b0;
        end
      end
    end
  end

endmodule // pwg_guard_lock
`default_nettype wire

/* File: testbench/pwg_guard_lock_monitor.sv */
/* Concurrent checks on the guard and lock block ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module pwg_guard_lock_monitor (
  // Clock, reset and bus answer.
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Start, reset and panel inputs, and drive core state.
  input wire logic forward_start_input_i,
  input wire logic reverse_start_input_i,
  input wire logic reset_terminal_input_i,
  input wire logic panel_set_key_i,
  input wire logic analog_negative_i,
  input wire logic above_start_speed_i,
  input wire logic fault_i,
  // Drive core commands.
  input wire logic run_o,
  input wire logic torque_oppose_o,
  input wire logic allow_forward_o,
  input wire logic allow_reverse_o,
  input wire logic output_shutoff_o,
  input wire logic thermal_clear_o,
  input wire logic panel_stop_indication_o,
  input wire logic alarm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // A panel stop that ends outside a block reset.
  sequence s_pstop_release;
    $fell(panel_stop_indication_o) && !$past(srst_i);
  endsequence
  // A panel stop that has stood for two cycles.
  sequence s_pstop_held;
    panel_stop_indication_o && $past(panel_stop_indication_o);
  endsequence
  chk_bus_okay:
    assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
    else $error("Bus answer not OKAY with ready.");
  chk_run_start:
    assert property (run_o |-> $past(forward_start_input_i ||
                                     reverse_start_input_i))
    else $error("Run without a start input.");
  chk_oppose_cause:
    assert property (torque_oppose_o |->
                     $past(analog_negative_i && above_start_speed_i))
    else $error("Opposing torque without its cause.");
  chk_fwd_permit:
    assert property (allow_forward_o |-> $past(forward_start_input_i))
    else $error("Forward permit without forward start.");
  chk_rev_permit:
    assert property (allow_reverse_o |-> $past(reverse_start_input_i))
    else $error("Reverse permit without reverse start.");
  chk_shut_cause:
    assert property (output_shutoff_o |-> $past(reset_terminal_input_i)
                     && thermal_clear_o && !run_o)
    else $error("Shutoff without reset or thermal clear.");
  chk_pstop_alarm:
    assert property (s_pstop_held |-> !alarm_o)
    else $error("Alarm raised during panel stop.");
  chk_alarm_cause:
    assert property (alarm_o |-> $past(fault_i))
    else $error("Alarm without a fault.");
  chk_pstop_halt:
    assert property (panel_stop_indication_o |=> !run_o)
    else $error("Run during panel stop.");
  // The latch clears one edge before the indication falls, so look back two.
  chk_pstop_exit:
    assert property (s_pstop_release |->
                     $past(reset_terminal_input_i || panel_set_key_i, 2))
    else $error("Panel stop left without reset or set key.");
endmodule // pwg_guard_lock_monitor
bind pwg_guard_lock pwg_guard_lock_monitor u_mon (
  .clk_i, .srst_i, .hreadyout_o, .hresp_o, .forward_start_input_i,
  .reverse_start_input_i, .reset_terminal_input_i, .panel_set_key_i,
  .analog_negative_i, .above_start_speed_i, .fault_i, .run_o,
  .torque_oppose_o, .allow_forward_o, .allow_reverse_o,
  .output_shutoff_o, .thermal_clear_o, .panel_stop_indication_o,
  .alarm_o);
`default_nettype wire

/* File: testbench/pwg_drive_model.sv */
/* Behavioural drive core that reports running after a run command.
   Assumes the block's clock and reset; the lag is one or two clocks. */
`timescale 1ns/100ps
`default_nettype none
module pwg_drive_model (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Run command in, running state out.
  input  wire logic run_i,
  input  wire logic slow_i,
  output var  logic motor_running_o
);
  logic run_q;
  // The shaft follows the command late, so a slow core lags one more.
  always @(posedge clk_i) begin
    run_q <= srst_i ? 1'b0 : run_i;
    motor_running_o <= srst_i ? 1'b0 : (slow_i ? run_q : run_i);
  end
endmodule // pwg_drive_model
`default_nettype wire

/* File: testbench/pwg_guard_lock_bench.sv */
/* Self-checking bench: bus tasks, a drive core model, and a table of
   start, reset and panel steps. Assumes the bound monitor. */
`timescale 1ns/100ps
`default_nettype none
module pwg_guard_lock_bench;
  // Each row: method, lock, inputs, output mask, expected outputs.
  localparam logic [31:0] TBL [0:20] = '{
    {2'd0, 2'd0, 10'h001, 9'h007, 9'h003}, {2'd0, 2'd0, 10'h002, 9'h007,
    9'h001}, {2'd0, 2'd0, 10'h005, 9'h007, 9'h001},
    {2'd0, 2'd1, 10'h002, 9'h001, 9'h000}, {2'd0, 2'd1, 10'h001, 9'h007,
    9'h003}, {2'd0, 2'd1, 10'h005, 9'h001, 9'h000},
    {2'd0, 2'd2, 10'h001, 9'h001, 9'h000}, {2'd1, 2'd1, 10'h005, 9'h001,
    9'h000}, {2'd1, 2'd1, 10'h00d, 9'h005, 9'h005},
    {2'd2, 2'd0, 10'h001, 9'h019, 9'h009}, {2'd2, 2'd0, 10'h002, 9'h019,
    9'h011}, {2'd2, 2'd1, 10'h002, 9'h011, 9'h000},
    {2'd0, 2'd0, 10'h001, 9'h000, 9'h000}, {2'd0, 2'd0, 10'h020, 9'h061,
    9'h060}, {2'd0, 2'd0, 10'h000, 9'h061, 9'h000},
    {2'd0, 2'd0, 10'h001, 9'h000, 9'h000}, {2'd0, 2'd0, 10'h041, 9'h081,
    9'h080}, {2'd0, 2'd0, 10'h010, 9'h180, 9'h080},
    {2'd0, 2'd0, 10'h020, 9'h080, 9'h000}, {2'd0, 2'd0, 10'h010, 9'h100,
    9'h100}, {2'd0, 2'd0, 10'h000, 9'h000, 9'h000}};
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [7:0]  haddr_i = 8'h00;
  logic [1:0]  htrans_i = 2'b00;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic [9:0]  iv = 10'h000;
  logic        slow = 1'b0;
  logic        running;
  wire  [8:0]  ov;
  logic [31:0] rd;
  int          fail_count = 0;
  int          n_checks = 0;
  // The 40 MHz clock.
  always #12.5 clk_i = ~clk_i;
  // Block under test and its drive core.
  pwg_guard_lock dut (.clk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hready_i(hreadyout_o), .hwdata_i,
    .hrdata_o, .hreadyout_o, .hresp_o(), .forward_start_input_i(iv[0]),
    .reverse_start_input_i(iv[1]), .analog_negative_i(iv[2]),
    .above_start_speed_i(iv[3]), .fault_i(iv[4]),
    .reset_terminal_input_i(iv[5]), .panel_stop_key_i(iv[6]),
    .panel_set_key_i(iv[7]), .mode_toggle_i(iv[8]),
    .comm_mode_req_i(iv[9]), .motor_running_i(running), .run_o(ov[0]),
    .dir_forward_o(ov[1]), .torque_oppose_o(ov[2]),
    .allow_forward_o(ov[3]), .allow_reverse_o(ov[4]),
    .output_shutoff_o(ov[5]), .thermal_clear_o(ov[6]),
    .panel_stop_indication_o(ov[7]), .alarm_o(ov[8]));
  pwg_drive_model u_core (.clk_i, .srst_i, .run_i(ov[0]), .slow_i(slow),
    .motor_running_o(running));
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic ck(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for ready at a rising edge, with a bounded count.
  task automatic rdy;
    int k;
    k = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      k++;
      if (k > 64) begin
        fail_count++;
        give_verdict();
      end
      @(posedge clk_i);
    end
  endtask
  // One single-word transfer, then an idle cycle so reads see writes.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= a;
    hwrite_i <= w;
    rdy();
    htrans_i <= 2'b00;
    hwdata_i <= d;
    rdy();
    rd = hrdata_o;
    @(posedge clk_i);
  endtask
  // Writes a parameter, then checks the reject flag in the status.
  task automatic pw(input logic [3:0] x, input logic [15:0] v,
                    input logic rej);
    bus(1'b1, 8'h00, {12'h000, x, v});
    bus(1'b0, 8'h08, 32'h0);
    ck("reject", {31'h0, rej}, {31'h0, rd[0]});
  endtask
  // Reads a parameter and compares it.
  task automatic cp(input logic [3:0] x, input logic [15:0] e);
    bus(1'b0, {2'b01, x, 2'b00}, 32'h0);
    ck("param", {16'h0, e}, rd);
  endtask
  // Reads the one-hot mode field of the status.
  task automatic cm(input logic [3:0] e);
    bus(1'b0, 8'h08, 32'h0);
    ck("mode", {28'h0, e}, {28'h0, rd[6:3]});
  endtask
  // Holds a set of inputs long enough for the core to follow.
  task automatic step(input logic [9:0] v, input int n);
    iv <= v;
    repeat (n) @(posedge clk_i);
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    cp(4'h2, 16'h000e);
    cm(4'h1);
    pw(4'h7, 16'h0005, 1'b1);
    cp(4'h7, 16'h0000);
    pw(4'h2, 16'h0002, 1'b0);
    step(10'h100, 1);
    step(10'h000, 3);
    cm(4'h2);
    pw(4'h7, 16'h0005, 1'b0);
    pw(4'h0, 16'h0001, 1'b0);
    pw(4'h7, 16'h0009, 1'b1);
    cp(4'h7, 16'h0005);
    pw(4'h4, 16'h0003, 1'b0);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'h08, 32'h0);
    ck("clear", 32'h1, {31'h0, rd[0]});
    cp(4'h7, 16'h0005);
    pw(4'h2, 16'h000e, 1'b0);
    pw(4'h0, 16'h0002, 1'b0);
    step(10'h100, 1);
    step(10'h001, 4);
    pw(4'h7, 16'h0006, 1'b0);
    pw(4'h5, 16'h0001, 1'b1);
    pw(4'h3, 16'h0001, 1'b1);
    cp(4'h5, 16'h0000);
    step(10'h000, 4);
    slow <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      pw(4'h6, {14'h0, TBL[i][31:30]}, 1'b0);
      pw(4'h1, {14'h0, TBL[i][29:28]}, 1'b0);
      step(TBL[i][27:18], 5);
      ck("drive", {23'h0, TBL[i][17:9] & TBL[i][8:0]},
         {23'h0, TBL[i][17:9] & ov});
    end
    // Stopped, so a protected slot takes a write; it forces combined mode.
    pw(4'h3, 16'h0003, 1'b0);
    cm(4'h4);
    // Stop key valid in panel or combined mode; reset needs a fault.
    pw(4'h2, 16'h0005, 1'b0);
    step(10'h001, 5);
    step(10'h041, 5);
    ck("pstop", 32'h2, {30'h0, ov[7], ov[0]});
    step(10'h080, 5);
    ck("release", 32'h0, {31'h0, ov[7]});
    step(10'h020, 5);
    ck("noreset", 32'h0, {30'h0, ov[6:5]});
    step(10'h030, 5);
    ck("faultreset", 32'h3, {30'h0, ov[6:5]});
    pw(4'h2, 16'h000f, 1'b0);
    bus(1'b1, 8'h04, 32'h1);
    cp(4'h7, 16'h0000);
    cp(4'h2, 16'h000f);
    step(10'h200, 1);
    step(10'h000, 3);
    cm(4'h8);
    give_verdict();
  end
endmodule // pwg_guard_lock_bench
`default_nettype wire
